// *** hw/ted_top.sv ***
// Purpose: One eight-bit timer, event counter and divider channel.
// Assumes: APB slave on the system clock at 200 MHz.
// Notes: Zero wait state bus; read data is captured in the setup cycle.
//
// Added by the designer: the placing of the registers and the APB register port.
`default_nettype none
`include "ted_defines.svh"

// Functional notes
// - Timer mode counts internal source, clears on match
// - Compare value takes effect right after write
// - Four fc sources; fs/2^3 alternative; slow fs only
// - Event mode counts pin falls, clears on match
// - Divider mode toggles flop, clears, interrupts
// - Divider pin drives inverted flop, square wave
// - Preset bit loads flop while stopped; reset clears it
// - Stopped divider output holds its level
// - Start at bit 3, preset at bit 7
// - Example control codes select timer and divider
module ted_top (
   input wire logic clock, // System clock, 200 MHz.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB write when high.
   input wire logic [7:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   input wire logic [3:0] pstrb, // APB byte strobes.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire logic fs_tick, // Low-frequency clock pulse.
   input wire logic event_input_pin, // External event pin.
   output logic divider_output_pin, // Divider output, inverted flop.
   output logic channel_match_irq, // One-cycle pulse per match.
   output logic irq // Level interrupt, masked status.
);
   ted_pkg::ted_core_s st_r; // Registered state.
   ted_pkg::ted_core_s st_nxt; // Next state.
   ted_src_if src (); // Link to prescaler and synchroniser.

   logic setup_ph; // APB setup cycle.
   logic acc_wr; // Write takes effect this edge.
   logic acc_rd; // Read completes this edge.
   logic addr_ok; // Address is mapped.
   logic running; // Start bit set.
   logic old_start; // Start bit before this edge.
   ted_pkg::ted_mode_e mode; // Current mode field.
   logic cnt_tick; // Counter advances this cycle.
   logic [7:0] cnt_inc; // Counter plus one.
   logic hit; // Counter reaches compare value.
   logic [31:0] rd_val; // Read mux output.

   // Source prescaler.
   ted_prescaler u_pre (
      .clock(clock),
      .rst_n(rst_n),
      .fs_tick(fs_tick),
      .src(src.pre)
   );

   // Event pin synchroniser and falling edge finder.
   ted_event_sync u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .event_input_pin(event_input_pin),
      .src(src.sync)
   );

   // Configuration handed to the prescaler straight from the registers.
   assign src.clk_sel = st_r.ctrl[`TED_CTRL_CLK_HI:`TED_CTRL_CLK_LO];
   assign src.alt_src = st_r.opt[`TED_OPT_SRC_SEL_BIT];
   assign src.slow = st_r.opt[`TED_OPT_SLOW_BIT];

   // Bus phase decode.
   assign setup_ph = psel & ~penable;
   assign acc_wr = psel & penable & pwrite & addr_ok;
   assign acc_rd = psel & penable & ~pwrite & addr_ok;

   // Address decode; anything else answers with an error.
   always_comb begin
      unique case (paddr)
         `TED_ADDR_CTRL,
         `TED_ADDR_CMP,
         `TED_ADDR_STAT,
         `TED_ADDR_IRQ_STS,
         `TED_ADDR_IRQ_MASK,
         `TED_ADDR_OPT: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // Read mux; narrow registers sit in the low bits, the rest reads zero.
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (paddr)
         `TED_ADDR_CTRL: rd_val[7:0] = st_r.ctrl;
         `TED_ADDR_CMP: rd_val[7:0] = st_r.cmp;
         `TED_ADDR_STAT: begin
            rd_val[7:0] = st_r.cnt;
            rd_val[`TED_STAT_FLOP_BIT] = st_r.flop;
            rd_val[`TED_STAT_RUN_BIT] = running;
         end
         `TED_ADDR_IRQ_STS: rd_val[0] = st_r.ists;
         `TED_ADDR_IRQ_MASK: rd_val[0] = st_r.mask;
         `TED_ADDR_OPT: rd_val[1:0] = st_r.opt;
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // Current control fields.
   assign old_start = st_r.ctrl[`TED_CTRL_START_BIT];
   assign running = old_start;
   assign mode = ted_pkg::ted_mode_e'(
      st_r.ctrl[`TED_CTRL_MODE_HI:`TED_CTRL_MODE_LO]);

   // Count source per mode; unsupported mode codes never count.
   always_comb begin
      unique case (mode)
         ted_pkg::TED_MODE_TIMER: cnt_tick = src.int_tick;
         ted_pkg::TED_MODE_DIVIDER: cnt_tick = src.int_tick;
         ted_pkg::TED_MODE_EVENT: cnt_tick = src.ev_fall;
         default: cnt_tick = 1'b0;
      endcase
   end

   // The compare value is read live from its register, so a write counts
   // from the very next tick; no shadow copy is kept.
   assign cnt_inc = st_r.cnt + 8'h01;
   assign hit = cnt_inc == st_r.cmp;

   // Next-state logic for the whole channel.
   always_comb begin
      st_nxt = st_r;
      st_nxt.match = 1'b0;

      // Counter: held at zero while stopped, so a start begins at zero.
      if (!running) begin
         st_nxt.cnt = 8'h00;
      end else if (cnt_tick) begin
         if (hit) begin
            // Match clears the counter and raises the request.
            st_nxt.cnt = 8'h00;
            st_nxt.match = 1'b1;
            // Divider mode also inverts the flop in the same event.
            if (mode == ted_pkg::TED_MODE_DIVIDER) begin
               st_nxt.flop = ~st_r.flop;
            end
         end else begin
            st_nxt.cnt = cnt_inc;
         end
      end

      // Register writes take effect at the access edge only.
      if (acc_wr && pstrb[0]) begin
         unique case (paddr)
            `TED_ADDR_CTRL: begin
               st_nxt.ctrl = pwdata[7:0];
               // The flop follows the preset bit only when the write lands
               // on a stopped channel. A stopping write leaves the flop
               // alone, so the output keeps its level after a stop.
               if (!old_start) begin
                  st_nxt.flop = pwdata[`TED_CTRL_PRESET_BIT];
               end else begin
                  st_nxt.flop = st_nxt.flop;
               end
            end
            `TED_ADDR_CMP: st_nxt.cmp = pwdata[7:0];
            `TED_ADDR_IRQ_MASK: st_nxt.mask = pwdata[0];
            `TED_ADDR_OPT: st_nxt.opt = pwdata[1:0];
            default: st_nxt.opt = st_nxt.opt;
         endcase
      end

      // Sticky status: a read clears it, a match in the same cycle wins.
      if (acc_rd && (paddr == `TED_ADDR_IRQ_STS)) begin
         st_nxt.ists = 1'b0;
      end
      if (st_nxt.match) begin
         st_nxt.ists = 1'b1;
      end

      // Read data and error are captured in the setup cycle so that the
      // access phase shows them from a flip-flop.
      if (setup_ph) begin
         st_nxt.prdata = pwrite ? 32'h0000_0000 : rd_val;
         st_nxt.pslverr = ~addr_ok;
      end
   end

   // State register, synchronous reset.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_r <= '{ctrl: `TED_CTRL_RST,
                   cmp: `TED_CMP_RST,
                   opt: `TED_OPT_RST,
                   mask: 1'b0,
                   ists: 1'b0,
                   cnt: 8'h00,
                   flop: `TED_FLOP_RST,
                   match: 1'b0,
                   prdata: 32'h0000_0000,
                   pslverr: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs. The divider pin shows the inverted flop in every mode, which
   // is why the preset bit should stay low outside divider mode.
   assign divider_output_pin = ~st_r.flop;
   assign channel_match_irq = st_r.match;
   assign irq = st_r.ists & st_r.mask;
   assign prdata = st_r.prdata;
   assign pslverr = st_r.pslverr & psel & penable;
   assign pready = 1'b1;
endmodule
`default_nettype wire

// *** pkg/ted_defines.svh ***
// Purpose: Offsets, field positions, reset values and counts for the timer.
// Assumes: Included by bare name; definitions only.
// Notes: Byte addresses on a 32-bit APB, one aligned word per register.
`ifndef TED_DEFINES_SVH
`define TED_DEFINES_SVH

// Register byte addresses.
`define TED_ADDR_CTRL 8'h00
`define TED_ADDR_CMP 8'h04
`define TED_ADDR_STAT 8'h08
`define TED_ADDR_IRQ_STS 8'h0C
`define TED_ADDR_IRQ_MASK 8'h10
`define TED_ADDR_OPT 8'h14

// Control register fields.
`define TED_CTRL_PRESET_BIT 7
`define TED_CTRL_CLK_HI 6
`define TED_CTRL_CLK_LO 4
`define TED_CTRL_START_BIT 3
`define TED_CTRL_MODE_HI 2
`define TED_CTRL_MODE_LO 0

// Option register fields.
`define TED_OPT_SRC_SEL_BIT 0
`define TED_OPT_SLOW_BIT 1

// Status register fields.
`define TED_STAT_FLOP_BIT 8
`define TED_STAT_RUN_BIT 9

// Reset values.
`define TED_CTRL_RST 8'h00
`define TED_CMP_RST 8'hFF
`define TED_OPT_RST 2'h0
`define TED_FLOP_RST 1'b0

// Prescaler widths: fc/2^11 needs 11 stages, fs/2^3 needs 3.
`define TED_DIV_W 11
`define TED_FS_DIV_W 3

`endif

// *** pkg/ted_pkg.sv ***
// Purpose: Types shared by the timer modules.
// Assumes: Field encodings match the control register layout.
// Notes: Codes not listed in the enums are illegal and handled by defaults.
`default_nettype none
package ted_pkg;

   // Operating mode field of the control register.
   typedef enum logic [2:0] {
      TED_MODE_TIMER = 3'h0,
      TED_MODE_DIVIDER = 3'h1,
      TED_MODE_EVENT = 3'h2
   } ted_mode_e;

   // Source clock field of the control register.
   typedef enum logic [2:0] {
      TED_CLK_DIV11 = 3'h0,
      TED_CLK_DIV7 = 3'h1,
      TED_CLK_DIV5 = 3'h2,
      TED_CLK_DIV3 = 3'h3
   } ted_clk_e;

   // Whole state of the channel core.
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] cmp;
      logic [1:0] opt;
      logic mask;
      logic ists;
      logic [7:0] cnt;
      logic flop;
      logic match;
      logic [31:0] prdata;
      logic pslverr;
   } ted_core_s;

   // Whole state of the prescaler.
   typedef struct packed {
      logic [10:0] div;
      logic [2:0] fsdiv;
      logic tick;
   } ted_pre_s;

   // Whole state of the event pin synchroniser.
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic fall;
   } ted_sync_s;

endpackage
`default_nettype wire

// *** pkg/ted_src_if.sv ***
// Purpose: Carries source selection and count pulses between modules.
// Assumes: All signals on the one system clock.
// Notes: Pulses are one clock wide.
`default_nettype none
interface ted_src_if;
   logic [2:0] clk_sel; // Selected internal source.
   logic alt_src; // Prescaler source select option.
   logic slow; // Slow or sleep power mode.
   logic int_tick; // Internal source pulse.
   logic ev_fall; // Falling edge seen on the event pin.

   modport core (output clk_sel, output alt_src, output slow,
                 input int_tick, input ev_fall);
   modport pre (input clk_sel, input alt_src, input slow,
                output int_tick);
   modport sync (output ev_fall);
endinterface
`default_nettype wire

// *** hw/ted_prescaler.sv ***
// Purpose: Divides the system clock into the selectable count sources.
// Assumes: clock is fc; fs_tick is a one-cycle pulse at the fs rate.
// Notes: A tick is one clock wide and comes from a flip-flop.
`default_nettype none
`include "ted_defines.svh"
module ted_prescaler (
   input wire logic clock, // System clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic fs_tick, // Low-frequency clock pulse.
   ted_src_if.pre src // Selection in, tick out.
);
   ted_pkg::ted_pre_s st_r; // Registered state.
   ted_pkg::ted_pre_s st_nxt; // Next state.
   logic [3:0] fc_tick; // fc/2^11, 2^7, 2^5, 2^3 pulses.
   logic fs_div_tick; // fs/2^3 pulse.

   // One compare per fc tap; each tap fires when its low bits are all ones.
   localparam int TAP [4] = '{11, 7, 5, 3};
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gen_tap
         assign fc_tick[g] = &st_r.div[TAP[g]-1:0];
      end
   endgenerate

   assign fs_div_tick = fs_tick & (&st_r.fsdiv);

   // Selection: slow modes only offer fs/2^3, which then ignores fc.
   always_comb begin
      st_nxt = st_r;
      st_nxt.div = st_r.div + 11'h001;
      st_nxt.fsdiv = fs_tick ? st_r.fsdiv + 3'h1 : st_r.fsdiv;
      st_nxt.tick = 1'b0;
      if (src.slow) begin
         // Other selections give no source at all in slow modes.
         st_nxt.tick = (src.clk_sel == 3'h0) & fs_div_tick;
      end else begin
         unique case (src.clk_sel)
            3'h0: st_nxt.tick = src.alt_src ? fs_div_tick : fc_tick[0];
            3'h1: st_nxt.tick = fc_tick[1];
            3'h2: st_nxt.tick = fc_tick[2];
            3'h3: st_nxt.tick = fc_tick[3];
            default: st_nxt.tick = 1'b0;
         endcase
      end
   end

   // State register.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign src.int_tick = st_r.tick;
endmodule
`default_nettype wire

// *** hw/ted_event_sync.sv ***
// Purpose: Brings the event pin into the clock domain and finds falls.
// Assumes: Each pin level lasts at least two machine cycles.
// Notes: Adds three clocks of latency from pin to pulse.
`default_nettype none
module ted_event_sync (
   input wire logic clock, // System clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic event_input_pin, // Asynchronous event pin.
   ted_src_if.sync src // Falling edge pulse out.
);
   ted_pkg::ted_sync_s st_r; // Registered state.
   ted_pkg::ted_sync_s st_nxt; // Next state.

   // Two flops synchronise; only the second and later stages are compared.
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = event_input_pin;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.fall = st_r.s3 & ~st_r.s2;
   end

   // State register; idle high so reset is not mistaken for a fall.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, fall: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign src.ev_fall = st_r.fall;
endmodule
`default_nettype wire

// *** tb/ted_top_assertions.sv ***
// Purpose: Port-level checks for the timer channel.
// Assumes: Sees only the ports of ted_top.
// Notes: Control writes are shadowed from the APB inputs.
`default_nettype none
`include "ted_defines.svh"
module ted_chk (
   input wire logic clock, // System clock.
   input wire logic rst_n, // Reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB write.
   input wire logic [7:0] paddr, // APB address.
   input wire logic [31:0] pwdata, // APB write data.
   input wire logic [3:0] pstrb, // APB strobes.
   input wire logic divider_output_pin, // Divider pin.
   input wire logic channel_match_irq, // Match pulse.
   input wire logic irq // Level interrupt.
);
   logic wr_ctrl; // A control write lands at this edge.
   logic run_r; // Shadowed start bit.
   logic pre_r; // Shadowed preset bit.
   logic [1:0] stop_r; // Stopped cycles, saturating at three.
   assign wr_ctrl = psel && penable && pwrite && pstrb[0] &&
      paddr == `TED_ADDR_CTRL;
   // The stop count lets a match already in flight drain first.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         run_r <= 1'b0;
         pre_r <= 1'b0;
      end else if (wr_ctrl) begin
         run_r <= pwdata[`TED_CTRL_START_BIT];
         pre_r <= pwdata[`TED_CTRL_PRESET_BIT];
      end
      if (!rst_n || run_r) begin
         stop_r <= 2'h0;
      end else if (stop_r != 2'h3) begin
         stop_r <= stop_r + 2'h1;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // No bus access in the last two cycles.
   sequence s_quiet;
      !$past(psel) && !$past(psel, 2);
   endsequence
   // Counter has been stopped long enough to settle.
   sequence s_stopped;
      stop_r == 2'h3;
   endsequence
   property p_pulse_one;
      channel_match_irq |=> !channel_match_irq [*3];
   endproperty
   a_pulse_one: assert property (p_pulse_one)
      else $error("match pulses too close");
   property p_irq_cause;
      $rose(irq) && !$past(psel) |-> ##[0:1] channel_match_irq;
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("interrupt without a match");
   property p_irq_hold;
      irq && !(psel && penable) |=> irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("interrupt dropped without access");
   property p_pin_cause;
      $changed(divider_output_pin) ##0 s_quiet |->
         $past(channel_match_irq) or ##[0:1] channel_match_irq;
   endproperty
   a_pin_cause: assert property (p_pin_cause)
      else $error("divider pin moved without a match");
   property p_stop_quiet;
      s_stopped |-> !channel_match_irq;
   endproperty
   a_stop_quiet: assert property (p_stop_quiet)
      else $error("match while stopped");
   property p_stop_hold;
      s_stopped ##0 s_quiet |-> $stable(divider_output_pin);
   endproperty
   a_stop_hold: assert property (p_stop_hold)
      else $error("divider pin moved while stopped");
   property p_preset;
      wr_ctrl && !run_r && !pwdata[`TED_CTRL_START_BIT] |->
         ##2 divider_output_pin == !pre_r;
   endproperty
   a_preset: assert property (p_preset)
      else $error("preset not seen on divider pin");
   property p_reset_pin;
      $rose(rst_n) |-> divider_output_pin;
   endproperty
   a_reset_pin: assert property (p_reset_pin)
      else $error("divider pin low after reset");
endmodule
bind ted_top ted_chk chk_u (
   .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .divider_output_pin(divider_output_pin),
   .channel_match_irq(channel_match_irq), .irq(irq));
`default_nettype wire

// *** tb/ted_far_side.sv ***
// Purpose: Event source, fs pulse and divider pin monitor.
// Assumes: Same clock as the channel.
// Notes: Event pin idles high between pulses.
`default_nettype none
module ted_far_side #(
   parameter int FS_DIV = 4, // Clocks per fs pulse.
   parameter int HALF = 4 // Clocks per event level.
) (
   input wire logic clock, // System clock.
   input wire logic rst_n, // Reset, active low.
   input wire logic divider_output_pin, // Pin under watch.
   output logic fs_tick, // Low-frequency pulse.
   output logic event_input_pin // Event pin.
);
   timeunit 1ns;
   timeprecision 100ps;
   int fs_cnt = 0; // Divider for the fs pulse.
   int run = 0; // Cycles since the pin last moved.
   int hi_len = 0; // Last complete high run.
   int lo_len = 0; // Last complete low run.
   logic last = 1'b1; // Pin level one cycle ago.
   initial event_input_pin = 1'b1;
   // The fs pulse is free running, like a watch crystal.
   always @(posedge clock) begin
      fs_cnt <= (fs_cnt == FS_DIV - 1) ? 0 : fs_cnt + 1;
      fs_tick <= rst_n && fs_cnt == FS_DIV - 1;
   end
   // Run lengths of each level show the duty cycle. The pin is watched
   // as if the shared port latch were already set to one.
   always @(posedge clock) begin
      if (divider_output_pin !== last) begin
         if (last) hi_len <= run;
         else lo_len <= run;
         run <= 1;
         last <= divider_output_pin;
      end else begin
         run <= run + 1;
      end
   end
   // Each level lasts HALF clocks so the sampler never misses one.
   task automatic send(input int n);
      repeat (n) begin
         @(posedge clock);
         event_input_pin <= 1'b0;
         repeat (HALF) @(posedge clock);
         event_input_pin <= 1'b1;
         repeat (HALF - 1) @(posedge clock);
      end
   endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the timer channel.
// Assumes: Zero wait state APB; far side model drives the pins.
// Notes: Periods are compare value times the source divider.
`default_nettype none
`include "ted_defines.svh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock; // System clock.
   logic rst_n = 1'b0; // Reset, active low.
   logic psel = 1'b0; // APB select.
   logic penable = 1'b0; // APB access phase.
   logic pwrite = 1'b0; // APB write.
   logic [7:0] paddr = 8'h00; // APB address.
   logic [31:0] pwdata = 32'h0; // APB write data.
   logic [3:0] pstrb = 4'hF; // All lanes written.
   logic [31:0] prdata; // APB read data.
   logic pready, pslverr; // APB answer.
   logic fs_tick, event_input_pin; // Far side pins.
   logic divider_output_pin, channel_match_irq, irq; // Outputs.
   int err_count, n_tests, n_match, p; // Counters, scratch.
   logic [31:0] rd; // Last read data.
   logic er, lv; // Last error flag, held pin level.
   // Timer table: option, source, compare, period (0 = no ticks).
   int t_opt[7] = '{0, 0, 0, 0, 1, 2, 2};
   int t_sel[7] = '{0, 1, 2, 3, 0, 0, 3};
   int t_cmp[7] = '{1, 2, 3, 5, 2, 3, 1};
   int t_per[7] = '{2048, 256, 96, 40, 64, 96, 0};
   ted_top dut_u (
      .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fs_tick(fs_tick), .event_input_pin(event_input_pin),
      .divider_output_pin(divider_output_pin),
      .channel_match_irq(channel_match_irq), .irq(irq));
   ted_far_side #(.FS_DIV(4), .HALF(4)) far_u (
      .clock(clock), .rst_n(rst_n), .fs_tick(fs_tick),
      .event_input_pin(event_input_pin),
      .divider_output_pin(divider_output_pin));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // Match pulses are counted for tests that check how many arrive.
   always @(posedge clock) begin
      if (channel_match_irq === 1'b1) n_match <= n_match + 1;
   end
   task automatic complete_run();
      $display("COUNTS compares=%0d mismatches=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic hang();
      err_count++;
      $display("FAIL %0t wait ran out", $time);
      complete_run();
   endtask
   task automatic chk(input logic [31:0] g, e, input string s);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("FAIL %0t %s got %h want %h", $time, s, g, e);
      end
   endtask
   // One APB transfer; the request stands until pready is seen.
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) hang();
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd, er);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e,
      input string s);
      apb(1'b0, a, 32'h0, rd, er);
      chk(rd, e, s);
   endtask
   // Cycles until the next match pulse, bounded.
   task automatic wait_match(output int c);
      c = 0;
      while (channel_match_irq !== 1'b1) begin
         @(posedge clock);
         c++;
         if (c > 5000) hang();
      end
   endtask
   // Distance between two successive match pulses.
   task automatic period(output int q);
      wait_match(q);
      @(posedge clock);
      wait_match(q);
      q++;
   endtask
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      rdc(`TED_ADDR_CTRL, 32'h0, "ctrl reset");
      rdc(`TED_ADDR_CMP, 32'hFF, "cmp reset");
      chk({31'h0, divider_output_pin}, 32'h1, "pin reset");
      apb(1'b0, 8'h20, 32'h0, rd, er);
      chk({31'h0, er}, 32'h1, "unmapped");
      wr(`TED_ADDR_IRQ_MASK, 32'h1);
      $display("TEST reset done");
      // Stop writes keep the source field, as software must.
      for (int i = 0; i < 7; i++) begin
         wr(`TED_ADDR_OPT, 32'(t_opt[i]));
         wr(`TED_ADDR_CMP, 32'(t_cmp[i]));
         wr(`TED_ADDR_CTRL, 32'(t_sel[i] * 16 + 8));
         if (t_per[i] > 0) begin
            period(p);
            chk(32'(p), 32'(t_per[i]), "timer period");
         end else begin
            p = n_match;
            repeat (300) @(posedge clock);
            chk(32'(n_match), 32'(p), "slow tick");
         end
         wr(`TED_ADDR_CTRL, 32'(t_sel[i] * 16));
         rdc(`TED_ADDR_STAT, 32'h0, "stopped");
      end
      wr(`TED_ADDR_OPT, 32'h0);
      wr(`TED_ADDR_IRQ_MASK, 32'h0);
      @(posedge clock);
      chk({31'h0, irq}, 32'h0, "masked");
      wr(`TED_ADDR_IRQ_MASK, 32'h1);
      @(posedge clock);
      chk({31'h0, irq}, 32'h1, "unmasked");
      rdc(`TED_ADDR_IRQ_STS, 32'h1, "sticky");
      @(posedge clock);
      chk({31'h0, irq}, 32'h0, "read clear");
      rdc(`TED_ADDR_IRQ_STS, 32'h0, "cleared");
      $display("TEST timer done");
      // Shrinking the compare early gives a match long before 255.
      wr(`TED_ADDR_CMP, 32'hFF);
      wr(`TED_ADDR_CTRL, 32'h38);
      wr(`TED_ADDR_CMP, 32'h3);
      wait_match(p);
      chk({31'h0, p < 40}, 32'h1, "compare late");
      wr(`TED_ADDR_CTRL, 32'h30);
      $display("TEST compare done");
      wr(`TED_ADDR_CMP, 32'h1);
      wr(`TED_ADDR_CTRL, 32'h11);
      wr(`TED_ADDR_CTRL, 32'h19);
      period(p);
      chk(32'(p), 32'd128, "divider period");
      repeat (2) begin
         @(posedge clock);
         wait_match(p);
      end
      repeat (4) @(posedge clock);
      chk(32'(far_u.hi_len), 32'd128, "high time");
      chk(32'(far_u.lo_len), 32'd128, "low time");
      wr(`TED_ADDR_CTRL, 32'h11);
      repeat (3) @(posedge clock);
      lv = divider_output_pin;
      repeat (50) @(posedge clock);
      chk({31'h0, divider_output_pin}, {31'h0, lv}, "held");
      rdc(`TED_ADDR_STAT, {23'h0, ~lv, 8'h00}, "flop");
      wr(`TED_ADDR_CTRL, 32'h91);
      repeat (2) @(posedge clock);
      chk({31'h0, divider_output_pin}, 32'h0, "preset");
      wr(`TED_ADDR_CTRL, 32'h11);
      repeat (2) @(posedge clock);
      chk({31'h0, divider_output_pin}, 32'h1, "unpreset");
      $display("TEST divider done");
      wr(`TED_ADDR_CMP, 32'h3);
      wr(`TED_ADDR_CTRL, 32'h0A);
      p = n_match;
      far_u.send(2);
      repeat (10) @(posedge clock);
      chk(32'(n_match), 32'(p), "early match");
      far_u.send(1);
      repeat (10) @(posedge clock);
      chk(32'(n_match), 32'(p + 1), "event match");
      far_u.send(3);
      repeat (10) @(posedge clock);
      chk(32'(n_match), 32'(p + 2), "resume");
      wr(`TED_ADDR_CTRL, 32'h02);
      $display("TEST event done");
      // An undefined mode code must run without ever counting.
      wr(`TED_ADDR_CTRL, 32'h3B);
      p = n_match;
      repeat (100) @(posedge clock);
      chk(32'(n_match), 32'(p), "bad mode");
      rdc(`TED_ADDR_STAT, 32'h200, "bad mode status");
      wr(`TED_ADDR_CTRL, 32'h33);
      $display("TEST mode done");
      complete_run();
   end
endmodule
`default_nettype wire
